// file: bench/tb_top.sv
// Self-checking bench for the fault unit
`timescale 1ns/1ps
`include "tpf_params.svh"

module tb_top;
    import tpf_pkg::*;
    logic         clock_in = 1'b0;
    logic         resetn_in;
    logic [7:0]   trace_controls_reg_in, issue_calls_index_in, sys_table_len_in;
    logic         trace_enable_bit_in, user_mode_in, issue_valid_in, issue_is_ret_in;
    logic         issue_privileged_in, issue_is_calls_in, done_valid_in, done_is_branch_in;
    logic         done_taken_in, done_is_call_in, done_is_bal_in, done_implicit_call_in;
    logic         done_is_ret_in, done_calls_super_in, done_is_mark_in, done_is_fmark_in;
    logic         done_bp_match_in, done_other_fault_in, irq_pending_in, wr_valid_in;
    logic         wr_super_mmr_in, wr_prot_ram_in, ram_prot_en_in, wr_timer_in, timer_prot_en_in;
    logic [2:0]   done_rrr_in;
    logic [31:0]  issue_ip_in, done_ip_in, done_next_ip_in, wr_ip_in, fault_ip_out, resume_instr_pointer_out;
    logic         pfp_preret_flag_in, handler_return_in, fault_valid_out, fault_ip_valid_out;
    logic         resume_valid_out, set_preret_flag_out, suppress_exec_out, trace_pending_out, trace_active_out;
    tpf_ftype_t   fault_type_out;
    tpf_subtype_t fault_subtype_out;
    int           n_fail = 0;
    int           total_checks = 0;
    int           cyc = 0;

    tpf_fault_unit u_dut (.*);

    tpf_disp_model u_disp (
        .clock_in           (clock_in),
        .resetn_in          (resetn_in),
        .fault_valid_in     (fault_valid_out),
        .fault_type_in      (fault_type_out),
        .set_preret_flag_in (set_preret_flag_out),
        .handler_return_out (handler_return_in),
        .preret_flag_out    (pfp_preret_flag_in)
    );

    always #10 clock_in = ~clock_in;

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            n_fail++;
            $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, s, e);
        end
    endtask

    task conclude;
        if (n_fail == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task tick;
        @(posedge clock_in);
        #2;
    endtask

    task clear;
        {trace_controls_reg_in, issue_calls_index_in, trace_enable_bit_in, user_mode_in} = '0;
        {issue_valid_in, issue_is_ret_in, issue_privileged_in, issue_is_calls_in, done_valid_in} = '0;
        {done_is_branch_in, done_taken_in, done_is_call_in, done_is_bal_in, done_implicit_call_in} = '0;
        {done_is_ret_in, done_calls_super_in, done_is_mark_in, done_is_fmark_in, done_bp_match_in} = '0;
        {done_other_fault_in, irq_pending_in, wr_valid_in, wr_super_mmr_in, wr_prot_ram_in} = '0;
        {ram_prot_en_in, wr_timer_in, timer_prot_en_in, done_rrr_in} = '0;
        resetn_in = 1'b0;
        sys_table_len_in = 8'h10;
        issue_ip_in = 32'h0000_2000;
        wr_ip_in = 32'h0000_3000;
        done_ip_in = 32'h0000_1000;
        done_next_ip_in = 32'h0000_1004;
    endtask

    task idle_wait;
        for (int i = 0; i < 20 && trace_active_out !== 1'b0; i++) tick;
        chk(trace_active_out, 1'b0);
    endtask

    task prot(input logic [7:0] idx, input logic exp);
        issue_valid_in = 1'b1;
        issue_is_calls_in = 1'b1;
        issue_calls_index_in = idx;
        tick;
        issue_valid_in = 1'b0;
        issue_is_calls_in = 1'b0;
        chk(fault_valid_out, exp);
        if (exp) begin
            chk(fault_type_out, `TPF_TYPE_PROT);
            chk(fault_subtype_out, `TPF_SUB_PROT_LEN);
            chk(fault_ip_out, issue_ip_in);
            chk(resume_instr_pointer_out, issue_ip_in);
            chk(suppress_exec_out, 1'b1);
        end
        tick;
    endtask

    task automatic types;
        logic [6:0] tv [8];
        tv = '{7'h60, 7'h20, 7'h50, 7'h10, 7'h0C, 7'h08, 7'h43, 7'h42};
        for (int i = 0; i < 8; i++) begin
            {user_mode_in, issue_privileged_in, wr_super_mmr_in, wr_prot_ram_in, ram_prot_en_in,
             wr_timer_in, timer_prot_en_in} = tv[i];
            issue_valid_in = 1'b1;
            wr_valid_in = 1'b1;
            tick;
            issue_valid_in = 1'b0;
            wr_valid_in = 1'b0;
            chk(fault_valid_out, i % 2 == 0);
            if (i % 2 == 0) begin
                chk(fault_type_out, `TPF_TYPE_TYPE);
                chk(fault_subtype_out, `TPF_SUB_TYPE_MISM);
                chk(fault_ip_out, (i == 0) ? issue_ip_in : wr_ip_in);
                chk(resume_valid_out, 1'b0);
                if (i == 0) chk(suppress_exec_out, 1'b1);
            end
            tick;
        end
        {user_mode_in, issue_privileged_in, wr_super_mmr_in, wr_prot_ram_in} = '0;
        {ram_prot_en_in, wr_timer_in, timer_prot_en_in} = '0;
    endtask

    task retire(input logic te, input logic [7:0] md, input logic [9:0] k,
                input logic [2:0] rrr, input logic [7:0] es, input logic ipv);
        trace_enable_bit_in = te;
        trace_controls_reg_in = md;
        {done_is_branch_in, done_taken_in, done_is_call_in, done_is_bal_in, done_implicit_call_in,
         done_is_ret_in, done_calls_super_in, done_is_mark_in, done_is_fmark_in, done_bp_match_in} = k;
        done_rrr_in = rrr;
        done_valid_in = 1'b1;
        tick;
        chk(fault_valid_out, es != 8'h00);
        if (es != 8'h00) begin
            chk(fault_type_out, `TPF_TYPE_TRACE);
            chk(fault_subtype_out, es);
            chk(resume_instr_pointer_out, done_next_ip_in);
            chk(resume_valid_out, 1'b1);
            chk(fault_ip_valid_out, ipv);
            if (ipv) chk(fault_ip_out, done_ip_in);
            tick;
            chk(fault_valid_out, 1'b0);
        end
        done_valid_in = 1'b0;
        tick;
        idle_wait;
    endtask

    task preret(input logic exp);
        trace_enable_bit_in = 1'b1;
        trace_controls_reg_in = 8'h20;
        {issue_valid_in, issue_is_ret_in, done_other_fault_in, irq_pending_in} = 4'hF;
        tick;
        {issue_valid_in, issue_is_ret_in, done_other_fault_in, irq_pending_in} = 4'h0;
        chk(fault_valid_out, exp);
        if (exp) begin
            chk(fault_subtype_out, 8'h20);
            chk(resume_instr_pointer_out, issue_ip_in);
            chk(suppress_exec_out, 1'b1);
            chk(fault_ip_valid_out, 1'b0);
            idle_wait;
        end
    endtask

    task defer(input logic irq);
        trace_controls_reg_in = 8'h02;
        irq_pending_in = irq;
        done_other_fault_in = !irq;
        done_valid_in = 1'b1;
        tick;
        done_valid_in = 1'b0;
        chk(fault_valid_out, 1'b0);
        tick;
        chk(trace_pending_out, 1'b1);
        irq_pending_in = 1'b0;
        done_other_fault_in = 1'b0;
        tick;
        chk(fault_valid_out, 1'b1);
        chk(fault_subtype_out, 8'h02);
        idle_wait;
    endtask

    always @(posedge clock_in) begin
        cyc++;
        if (cyc == 3000) begin
            n_fail++;
            conclude;
        end
    end

    initial begin
        clear;
        repeat (3) @(posedge clock_in);
        chk(fault_valid_out, 1'b0);
        #2;
        resetn_in = 1'b1;
        tick;
        chk(trace_active_out, 1'b0);
        chk(trace_pending_out, 1'b0);
        prot(8'h10, 1'b1);
        prot(8'h0F, 1'b0);
        prot(8'hFF, 1'b1);
        types;
        retire(1'b1, 8'h02, 10'h000, 3'h0, 8'h02, 1'b1);
        retire(1'b0, 8'h02, 10'h000, 3'h0, 8'h00, 1'b1);
        retire(1'b1, 8'h00, 10'h080, 3'h0, 8'h00, 1'b1);
        retire(1'b1, 8'h04, 10'h300, 3'h0, 8'h04, 1'b1);
        retire(1'b1, 8'h04, 10'h200, 3'h0, 8'h00, 1'b1);
        retire(1'b1, 8'h04, 10'h340, 3'h0, 8'h00, 1'b1);
        preret(1'b0);
        retire(1'b1, 8'h08, 10'h080, 3'h0, 8'h08, 1'b1);
        chk(pfp_preret_flag_in, 1'b1);
        retire(1'b1, 8'h08, 10'h040, 3'h0, 8'h08, 1'b1);
        retire(1'b1, 8'h08, 10'h020, 3'h0, 8'h08, 1'b0);
        retire(1'b1, 8'h10, 10'h010, 3'h0, 8'h10, 1'b1);
        retire(1'b1, 8'h40, 10'h008, 3'h0, 8'h40, 1'b1);
        retire(1'b1, 8'h40, 10'h010, 3'h2, 8'h40, 1'b1);
        retire(1'b1, 8'h40, 10'h010, 3'h3, 8'h40, 1'b1);
        retire(1'b1, 8'h40, 10'h010, 3'h1, 8'h00, 1'b1);
        retire(1'b1, 8'h80, 10'h004, 3'h0, 8'h80, 1'b1);
        retire(1'b1, 8'h80, 10'h002, 3'h0, 8'h80, 1'b1);
        retire(1'b1, 8'h80, 10'h001, 3'h0, 8'h80, 1'b1);
        retire(1'b1, 8'h0E, 10'h080, 3'h0, 8'h0A, 1'b1);
        preret(1'b1);
        defer(1'b0);
        defer(1'b1);
        conclude;
    end
endmodule

// file: bench/tpf_disp_model.sv
// Dispatch and frame model on the far side of the fault unit
`timescale 1ns/1ps
`include "tpf_params.svh"

module tpf_disp_model (
    // Clock and reset
    input  wire logic       clock_in,
    input  wire logic       resetn_in,
    // Fault report from the unit
    input  wire logic       fault_valid_in,
    input  wire logic [3:0] fault_type_in,
    input  wire logic       set_preret_flag_in,
    // Handler return and current frame flag
    output logic            handler_return_out,
    output logic            preret_flag_out
);
    logic [2:0] wait_r;

    // Trace handler runs a few cycles, then returns
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            wait_r <= 3'h0;
            handler_return_out <= 1'b0;
            preret_flag_out <= 1'b0;
        end else begin
            handler_return_out <= (wait_r == 3'h1);
            if (fault_valid_in && fault_type_in == `TPF_TYPE_TRACE) begin
                wait_r <= 3'h5;
            end else if (wait_r != 3'h0) begin
                wait_r <= wait_r - 3'h1;
            end
            if (set_preret_flag_in) begin
                preret_flag_out <= 1'b1;
            end
        end
    end
endmodule

// file: common/tpf_params.svh
// Constants for the trace, protection and type fault unit
`ifndef TPF_PARAMS_SVH
`define TPF_PARAMS_SVH

`define TPF_TYPE_TRACE      4'h1
`define TPF_TYPE_PROT       4'h7
`define TPF_TYPE_TYPE       4'hA
`define TPF_SUB_PROT_LEN    8'h02
`define TPF_SUB_TYPE_MISM   8'h01
`define TPF_BIT_INSTR       1
`define TPF_BIT_BRANCH      2
`define TPF_BIT_CALL        3
`define TPF_BIT_RETURN      4
`define TPF_BIT_PRERET      5
`define TPF_BIT_SUPER       6
`define TPF_BIT_MARK        7
`define TPF_RRR_SUPER_A     3'h2
`define TPF_RRR_SUPER_B     3'h3
`define TPF_PFP_PRERET_BIT  3
`define TPF_RESET_SUBTYPE   8'h00
`define TPF_RESET_TYPE      4'h0

`endif

// file: common/tpf_pkg.sv
// Types for the trace, protection and type fault unit
package tpf_pkg;
    typedef logic [3:0] tpf_ftype_t;
    typedef logic [7:0] tpf_subtype_t;
    typedef enum logic [1:0] {
        TPF_HANDLER_NONE,
        TPF_HANDLER_TRACE,
        TPF_HANDLER_OTHER
    } tpf_handler_e;
endpackage

// file: logic/tpf_fault_unit.sv
// Trace, protection and type fault detection and reporting
`timescale 1ns/1ps
`include "tpf_params.svh"

module tpf_fault_unit #(
    parameter int ADDR_W = 32,
    parameter int IDX_W  = 8
) (
    // Clock and reset
    input  wire logic                 clock_in,
    input  wire logic                 resetn_in,
    // Trace and process controls
    input  wire logic [7:0]           trace_controls_reg_in,
    input  wire logic                 trace_enable_bit_in,
    input  wire logic                 user_mode_in,
    // Issue stage, before execution
    input  wire logic                 issue_valid_in,
    input  wire logic [ADDR_W-1:0]    issue_ip_in,
    input  wire logic                 issue_is_ret_in,
    input  wire logic                 pfp_preret_flag_in,
    input  wire logic                 issue_privileged_in,
    input  wire logic                 issue_is_calls_in,
    input  wire logic [IDX_W-1:0]     issue_calls_index_in,
    input  wire logic [IDX_W-1:0]     sys_table_len_in,
    // Retire stage, after execution
    input  wire logic                 done_valid_in,
    input  wire logic [ADDR_W-1:0]    done_ip_in,
    input  wire logic [ADDR_W-1:0]    done_next_ip_in,
    input  wire logic                 done_is_branch_in,
    input  wire logic                 done_taken_in,
    input  wire logic                 done_is_call_in,
    input  wire logic                 done_is_bal_in,
    input  wire logic                 done_implicit_call_in,
    input  wire logic                 done_is_ret_in,
    input  wire logic                 done_calls_super_in,
    input  wire logic [2:0]           done_rrr_in,
    input  wire logic                 done_is_mark_in,
    input  wire logic                 done_is_fmark_in,
    input  wire logic                 done_bp_match_in,
    input  wire logic                 done_other_fault_in,
    input  wire logic                 irq_pending_in,
    // Memory-mapped write checks
    input  wire logic                 wr_valid_in,
    input  wire logic                 wr_super_mmr_in,
    input  wire logic                 wr_prot_ram_in,
    input  wire logic                 ram_prot_en_in,
    input  wire logic                 wr_timer_in,
    input  wire logic                 timer_prot_en_in,
    input  wire logic [ADDR_W-1:0]    wr_ip_in,
    // Handler return from dispatch
    input  wire logic                 handler_return_in,
    // Fault report to dispatch
    output logic                      fault_valid_out,
    output tpf_pkg::tpf_ftype_t       fault_type_out,
    output tpf_pkg::tpf_subtype_t     fault_subtype_out,
    output logic [ADDR_W-1:0]         fault_ip_out,
    output logic                      fault_ip_valid_out,
    output logic [ADDR_W-1:0]         resume_instr_pointer_out,
    output logic                      resume_valid_out,
    output logic                      set_preret_flag_out,
    output logic                      suppress_exec_out,
    output logic                      trace_pending_out,
    output logic                      trace_active_out
);
    import tpf_pkg::*;

    if (ADDR_W < 2 || IDX_W < 1) begin : g_bad_width
        $error("tpf_fault_unit: bad widths");
    end

    // Set inside the trace handler; clears the trace enable as seen by the logic
    logic               in_trace_h_r;
    logic               trace_pending_r;
    tpf_subtype_t       pend_sub_r;
    logic [ADDR_W-1:0]  pend_ip_r;
    logic [ADDR_W-1:0]  pend_next_r;
    logic               pend_implicit_r;

    logic               fault_valid_r;
    tpf_ftype_t         fault_type_r;
    tpf_subtype_t       fault_subtype_r;
    logic [ADDR_W-1:0]  fault_ip_r;
    logic               fault_ip_valid_r;
    logic [ADDR_W-1:0]  rip_r;
    logic               rip_valid_r;
    logic               set_preret_r;
    logic               suppress_r;

    wire logic te_eff = trace_enable_bit_in && !in_trace_h_r;

    // Issue-time and memory-mapped write checks
    wire logic prot_hit  = issue_valid_in && issue_is_calls_in &&
                           (issue_calls_index_in >= sys_table_len_in);
    wire logic priv_hit  = issue_valid_in && user_mode_in && issue_privileged_in;
    wire logic preret_hit = issue_valid_in && issue_is_ret_in && pfp_preret_flag_in &&
                            trace_controls_reg_in[`TPF_BIT_PRERET] && te_eff;
    wire logic wr_hit    = wr_valid_in && ((wr_super_mmr_in && user_mode_in) ||
                           (wr_prot_ram_in && ram_prot_en_in) ||
                           (wr_timer_in && timer_prot_en_in && user_mode_in));

    // Retire-time trace detection
    logic [7:0] det_events;
    tpf_trace_detect u_detect (
        .mode_in           (trace_controls_reg_in),
        .is_branch_in      (done_is_branch_in),
        .taken_in          (done_taken_in),
        .is_call_in        (done_is_call_in),
        .is_bal_in         (done_is_bal_in),
        .implicit_call_in  (done_implicit_call_in),
        .is_ret_in         (done_is_ret_in),
        .is_calls_super_in (done_calls_super_in),
        .rrr_in            (done_rrr_in),
        .is_mark_in        (done_is_mark_in),
        .is_fmark_in       (done_is_fmark_in),
        .bp_match_in       (done_bp_match_in),
        .events_out        (det_events)
    );

    wire logic       done_trace = done_valid_in && te_eff && (det_events != 8'h00);
    // Trace waits while another fault or interrupt is taken first
    wire logic       defer      = done_other_fault_in || irq_pending_in;
    wire logic       busy       = prot_hit || priv_hit || preret_hit || wr_hit;
    wire logic       fire_pend  = trace_pending_r && !defer && !busy && !done_trace;
    wire logic       fire_now   = done_trace && !defer && !busy && !trace_pending_r;
    wire logic       fire_trace = fire_pend || fire_now;
    wire tpf_subtype_t tr_sub   = fire_pend ? pend_sub_r : det_events;
    wire logic [ADDR_W-1:0] tr_ip   = fire_pend ? pend_ip_r : done_ip_in;
    wire logic [ADDR_W-1:0] tr_next = fire_pend ? pend_next_r : done_next_ip_in;
    wire logic       tr_impl    = fire_pend ? pend_implicit_r : done_implicit_call_in;
    wire logic       tr_call    = tr_sub[`TPF_BIT_CALL];

    // Pending trace capture, held until it fires or a protection fault clears it
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            trace_pending_r <= 1'b0;
            pend_sub_r      <= `TPF_RESET_SUBTYPE;
            pend_ip_r       <= '0;
            pend_next_r     <= '0;
            pend_implicit_r <= 1'b0;
        end else if (done_trace && !fire_now && !trace_pending_r) begin
            trace_pending_r <= 1'b1;
            pend_sub_r      <= det_events;
            pend_ip_r       <= done_ip_in;
            pend_next_r     <= done_next_ip_in;
            pend_implicit_r <= done_implicit_call_in;
        end else if (fire_pend || prot_hit) begin
            trace_pending_r <= 1'b0;
        end
    end

    // Handler state: tracing is cleared on trace-handler entry
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            in_trace_h_r <= 1'b0;
        end else if ((fire_trace || preret_hit) && !in_trace_h_r) begin
            in_trace_h_r <= 1'b1;
        end else if (handler_return_in) begin
            in_trace_h_r <= 1'b0;
        end
    end

    // Report selection, by priority
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            fault_valid_r    <= 1'b0;
            fault_type_r     <= `TPF_RESET_TYPE;
            fault_subtype_r  <= `TPF_RESET_SUBTYPE;
            fault_ip_r       <= '0;
            fault_ip_valid_r <= 1'b0;
            rip_r            <= '0;
            rip_valid_r      <= 1'b0;
            set_preret_r     <= 1'b0;
            suppress_r       <= 1'b0;
        end else begin
            fault_valid_r <= 1'b0;
            set_preret_r  <= 1'b0;
            suppress_r    <= 1'b0;
            if (preret_hit) begin
                fault_valid_r    <= 1'b1;
                fault_type_r     <= `TPF_TYPE_TRACE;
                fault_subtype_r  <= 8'h01 << `TPF_BIT_PRERET;
                fault_ip_valid_r <= 1'b0;
                rip_r            <= issue_ip_in;
                rip_valid_r      <= 1'b1;
                suppress_r       <= 1'b1;
            end else if (prot_hit) begin
                fault_valid_r    <= 1'b1;
                fault_type_r     <= `TPF_TYPE_PROT;
                fault_subtype_r  <= `TPF_SUB_PROT_LEN;
                fault_ip_r       <= issue_ip_in;
                fault_ip_valid_r <= 1'b1;
                rip_r            <= issue_ip_in;
                rip_valid_r      <= 1'b1;
                suppress_r       <= 1'b1;
            end else if (priv_hit || wr_hit) begin
                fault_valid_r    <= 1'b1;
                fault_type_r     <= `TPF_TYPE_TYPE;
                fault_subtype_r  <= `TPF_SUB_TYPE_MISM;
                fault_ip_r       <= priv_hit ? issue_ip_in : wr_ip_in;
                fault_ip_valid_r <= 1'b1;
                rip_valid_r      <= 1'b0;
                suppress_r       <= 1'b1;
            end else if (fire_trace) begin
                fault_valid_r    <= 1'b1;
                fault_type_r     <= `TPF_TYPE_TRACE;
                fault_subtype_r  <= tr_sub;
                fault_ip_r       <= tr_ip;
                fault_ip_valid_r <= !(tr_impl && tr_call);
                rip_r            <= tr_next;
                rip_valid_r      <= 1'b1;
                set_preret_r     <= tr_call;
            end
        end
    end

    assign fault_valid_out          = fault_valid_r;
    assign fault_type_out           = fault_type_r;
    assign fault_subtype_out        = fault_subtype_r;
    assign fault_ip_out             = fault_ip_r;
    assign fault_ip_valid_out       = fault_ip_valid_r;
    assign resume_instr_pointer_out = rip_r;
    assign resume_valid_out         = rip_valid_r;
    assign set_preret_flag_out      = set_preret_r;
    assign suppress_exec_out        = suppress_r;
    assign trace_pending_out        = trace_pending_r;
    assign trace_active_out         = in_trace_h_r;

    // Checks
    property p_prot;
        @(posedge clock_in) disable iff (!resetn_in)
        (prot_hit && !preret_hit) |=> fault_valid_out && fault_type_out == 4'h7 && fault_subtype_out == 8'h02
            && resume_instr_pointer_out == fault_ip_out && suppress_exec_out;
    endproperty
    a_prot: assert property (p_prot) else $error("protection fault report wrong");

    property p_preret_alone;
        @(posedge clock_in) disable iff (!resetn_in)
        preret_hit |=> fault_subtype_out == 8'h20 && !fault_ip_valid_out && suppress_exec_out;
    endproperty
    a_preret_alone: assert property (p_preret_alone) else $error("prereturn not alone");

    property p_te_gate;
        @(posedge clock_in) disable iff (!resetn_in)
        (!trace_enable_bit_in && !trace_pending_r && !preret_hit) |=> !(fault_valid_out && fault_type_out == 4'h1);
    endproperty
    a_te_gate: assert property (p_te_gate) else $error("trace without enable");

    property p_defer;
        @(posedge clock_in) disable iff (!resetn_in)
        (done_trace && defer && !trace_pending_r) |=> trace_pending_r;
    endproperty
    a_defer: assert property (p_defer) else $error("trace not held behind other event");

    property p_irq;
        @(posedge clock_in) disable iff (!resetn_in)
        (irq_pending_in && !preret_hit) |=> !(fault_valid_out && fault_type_out == 4'h1);
    endproperty
    a_irq: assert property (p_irq) else $error("trace before interrupt");

    property p_handler;
        @(posedge clock_in) disable iff (!resetn_in)
        (fire_trace && !in_trace_h_r && !handler_return_in) |=> in_trace_h_r;
    endproperty
    a_handler: assert property (p_handler) else $error("tracing not cleared in handler");

    property p_rip;
        @(posedge clock_in) disable iff (!resetn_in)
        (fire_now && !preret_hit && !busy) |=> resume_instr_pointer_out == $past(done_next_ip_in);
    endproperty
    a_rip: assert property (p_rip) else $error("trace resume pointer wrong");

    property p_type;
        @(posedge clock_in) disable iff (!resetn_in)
        (priv_hit && !prot_hit && !preret_hit) |=> fault_type_out == 4'hA && fault_ip_out == $past(issue_ip_in)
            && !resume_valid_out;
    endproperty
    a_type: assert property (p_type) else $error("type fault report wrong");

    property p_call_flag;
        @(posedge clock_in) disable iff (!resetn_in)
        (fire_trace && tr_call && !busy) |=> set_preret_flag_out;
    endproperty
    a_call_flag: assert property (p_call_flag) else $error("prereturn flag not set");
endmodule

// file: logic/tpf_trace_detect.sv
// Combinational detector of the trace event kinds for one instruction
`timescale 1ns/1ps
`include "tpf_params.svh"

module tpf_trace_detect (
    // Trace controls mode bits, bit n enables subtype n
    input  wire logic [7:0] mode_in,
    // Retired instruction description
    input  wire logic       is_branch_in,
    input  wire logic       taken_in,
    input  wire logic       is_call_in,
    input  wire logic       is_bal_in,
    input  wire logic       implicit_call_in,
    input  wire logic       is_ret_in,
    input  wire logic       is_calls_super_in,
    input  wire logic [2:0] rrr_in,
    input  wire logic       is_mark_in,
    input  wire logic       is_fmark_in,
    input  wire logic       bp_match_in,
    // Detected subtype bits, before the trace enable gate
    output logic      [7:0] events_out
);
    wire logic ev_instr  = 1'b1;
    wire logic ev_branch = is_branch_in && taken_in && !is_call_in && !is_bal_in;
    wire logic ev_call   = is_call_in || is_bal_in || implicit_call_in;
    wire logic ev_super  = is_calls_super_in ||
                           (is_ret_in && (rrr_in == `TPF_RRR_SUPER_A || rrr_in == `TPF_RRR_SUPER_B));
    wire logic ev_mark   = is_mark_in || is_fmark_in || bp_match_in;
    wire logic [7:0] raw = {ev_mark, ev_super, 1'b0, is_ret_in, ev_call, ev_branch, ev_instr, 1'b0};

    assign events_out = raw & mode_in & 8'hDE;
endmodule
